// file: logic/sbrg_regs.svh
// Register map, field positions and reset values of the bit-rate generator.
// Assumes a 12-bit APB byte address with one 32-bit word per register.
`ifndef SBRG_REGS_SVH
`define SBRG_REGS_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define SBRG_OFF_MODE 12'h000
`define SBRG_OFF_DIVISOR 12'h004
`define SBRG_OFF_STC 12'h008
`define SBRG_OFF_WAIT 12'h00c
`define SBRG_OFF_SRC 12'h010
`define SBRG_OFF_STATUS 12'h014

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define SBRG_MODE_SYNC_BIT 7
`define SBRG_MODE_MP_BIT 2
`define SBRG_STC_MPE_BIT 2
`define SBRG_STC_ACK_BIT 3
`define SBRG_WAIT_CLOCK_DOUBLE_DIVIDE_BIT 3
`define SBRG_WAIT_PHALF_BIT 0
`define SBRG_SRC_CLOCK_SOURCE_ENABLE_LO_BIT 0
`define SBRG_SRC_CLOCK_SOURCE_ENABLE_HI_BIT 1

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SBRG_MODE_RST 8'h00
`define SBRG_DIVISOR_RST 8'hff
`define SBRG_STC_RST 8'h00
`define SBRG_WAIT_RST 8'h00
`define SBRG_SRC_RST 2'h0
`define SBRG_X16_LAST 4'hf
`define SBRG_X16_SAMPLE 4'h7
`define SBRG_SYNC_HALF_LAST 2'h3

`endif

// file: logic/sbrg_pkg.sv
// Types shared by the bit-rate generator modules.
// Assumes nothing beyond a SystemVerilog compiler.
package sbrg_pkg;
  typedef logic [7:0] sbrg_byte_t;
  typedef logic [1:0] sbrg_cks_t;
  typedef enum logic {SBRG_ASYNC, SBRG_SYNC} sbrg_mode_e;
endpackage

// file: logic/sbrg_tick_if.sv
// Tick carrier between the prescaler, the divisor counter and the top.
// Assumes all three run on pclk.
`timescale 1ns/100ps
interface sbrg_tick_if;
  logic pre_tick;
  logic half_tick;
  modport src (output pre_tick);
  modport div (input pre_tick, output half_tick);
  modport sink (input half_tick);
endinterface

// file: logic/sbrg_prescaler.sv
// Input clock selection and prescaler of the bit-rate generator.
// Assumes pclk is the system clock and the peripheral clock is pclk or
// pclk/2, the latter made here as an enable on every other cycle.
`timescale 1ns/100ps
module sbrg_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire sbrg_pkg::sbrg_cks_t cks,
  input wire logic clock_double_divide,
  input wire logic periph_half,
  sbrg_tick_if.src tick
);
  import sbrg_pkg::*;

  logic periph_ph_q;
  logic [6:0] cnt_q;
  logic [6:0] last;
  logic base_en;

  // Last count of each prescale ratio
  function automatic logic [6:0] pre_last(input sbrg_cks_t n,
                                          input logic dbl);
    unique case (n)
      2'h0: pre_last = 7'h00;
      2'h1: pre_last = dbl ? 7'h07 : 7'h03;
      2'h2: pre_last = dbl ? 7'h1f : 7'h0f;
      2'h3: pre_last = dbl ? 7'h7f : 7'h3f;
    endcase
  endfunction

  assign last = pre_last(cks, clock_double_divide);
  // System clock for n of zero, peripheral clock otherwise
  assign base_en = (cks == 2'h0) | ~periph_half | periph_ph_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) periph_ph_q <= 1'b0;
    else periph_ph_q <= ~periph_ph_q;
  end

  // A ratio change restarts cleanly since cnt_q is clamped by >=
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
    end else if (base_en) begin
      if (cnt_q >= last) cnt_q <= 7'h00;
      else cnt_q <= cnt_q + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick.pre_tick <= 1'b0;
    else tick.pre_tick <= base_en & (cnt_q >= last);
  end
endmodule

// file: logic/sbrg_divider.sv
// Divisor counter: one half_tick every N+1 prescaled ticks.
// Assumes pre_tick is a one-cycle pulse on pclk.
`timescale 1ns/100ps
module sbrg_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire sbrg_pkg::sbrg_byte_t divisor,
  sbrg_tick_if.div tick
);
  import sbrg_pkg::*;

  sbrg_byte_t cnt_q;
  sbrg_byte_t reload_q;

  // Divisor is taken only at terminal count, so a write never cuts a
  // period short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      reload_q <= 8'h00;
    end else if (tick.pre_tick) begin
      if (cnt_q == reload_q) begin
        cnt_q <= 8'h00;
        reload_q <= divisor;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick.half_tick <= 1'b0;
    else tick.half_tick <= tick.pre_tick & (cnt_q == reload_q);
  end
endmodule

// file: logic/sbrg_top.sv
// Bit-rate generator top: APB registers, clock source choice, bit and
// sample timing, multiprocessor enable and pass-through control bits.
// Assumes an APB master on pclk and an external serial clock pin that is
// asynchronous to pclk.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "sbrg_regs.svh"

module sbrg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_sck_in,
  output logic sck_out,
  output logic sck_oe,
  output logic bit_tick,
  output logic x16_tick,
  output logic sample_strobe,
  output logic mp_format,
  output logic [1:0] timer_clock_select,
  output logic [3:0] i2c_control,
  output logic slave_input_switch
);
  import sbrg_pkg::*;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  sbrg_byte_t mode_q;
  sbrg_byte_t divisor_q;
  sbrg_byte_t stc_q;
  sbrg_byte_t wait_q;
  logic [1:0] src_q;
  logic [31:0] rdata_d;
  logic hit;
  logic access;
  logic wr_en;
  logic lane0;

  sbrg_mode_e mode;
  logic internal;
  logic max_rate;

  // ----------------------------------------------------------------------
  // External clock synchroniser
  // ----------------------------------------------------------------------
  logic sck_s1_q;
  logic sck_s2_q;
  logic sck_s3_q;
  logic sck_lvl_q;
  logic ext_rise;

  // ----------------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------------
  logic [1:0] ph_q;
  logic [3:0] cnt16_q;
  logic x16_evt;
  logic sync_evt;

  sbrg_tick_if tick_bus ();

  // Address decode, shared by the error response and write enable
  function automatic logic addr_known(input logic [11:0] a);
    unique case (a)
      `SBRG_OFF_MODE, `SBRG_OFF_DIVISOR, `SBRG_OFF_STC,
      `SBRG_OFF_WAIT, `SBRG_OFF_SRC, `SBRG_OFF_STATUS: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // One wait state: pready rises the cycle after the access phase starts,
  // so read data can come from a flop
  assign hit = addr_known(paddr);
  assign access = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite & hit;
  assign lane0 = pstrb[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access & ~hit;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      `SBRG_OFF_MODE: rdata_d[7:0] = mode_q;
      `SBRG_OFF_DIVISOR: rdata_d[7:0] = divisor_q;
      `SBRG_OFF_STC: rdata_d[7:0] = stc_q;
      `SBRG_OFF_WAIT: rdata_d[7:0] = wait_q;
      `SBRG_OFF_SRC: rdata_d[1:0] = src_q;
      `SBRG_OFF_STATUS: rdata_d[4:0] = {max_rate, mp_format, sck_lvl_q,
                                        sck_out, internal};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (access & ~pwrite) prdata <= rdata_d;
  end

  // Only byte lane 0 carries register bits; other lanes are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `SBRG_MODE_RST;
      divisor_q <= `SBRG_DIVISOR_RST;
      stc_q <= `SBRG_STC_RST;
      wait_q <= `SBRG_WAIT_RST;
      src_q <= `SBRG_SRC_RST;
    end else if (wr_en & lane0) begin
      unique case (paddr)
        `SBRG_OFF_MODE: mode_q <= pwdata[7:0];
        `SBRG_OFF_DIVISOR: divisor_q <= pwdata[7:0];
        `SBRG_OFF_STC: stc_q <= pwdata[7:0];
        `SBRG_OFF_WAIT: wait_q <= pwdata[7:0];
        `SBRG_OFF_SRC: src_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Mode and source decode
  // ----------------------------------------------------------------------
  assign mode = mode_q[`SBRG_MODE_SYNC_BIT] ? SBRG_SYNC : SBRG_ASYNC;
  assign internal = ~src_q[`SBRG_SRC_CLOCK_SOURCE_ENABLE_HI_BIT];
  // Fastest sync setting is legal; the transmitter must pace itself
  assign max_rate = (mode == SBRG_SYNC) & (mode_q[1:0] == 2'h0)
                  & (divisor_q == 8'h00);

  // ----------------------------------------------------------------------
  // Prescaler and divisor counter
  // ----------------------------------------------------------------------
  sbrg_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .cks(mode_q[1:0]),
    .clock_double_divide(wait_q[`SBRG_WAIT_CLOCK_DOUBLE_DIVIDE_BIT]),
    .periph_half(wait_q[`SBRG_WAIT_PHALF_BIT]),
    .tick(tick_bus.src)
  );

  sbrg_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(divisor_q),
    .tick(tick_bus.div)
  );

  // ----------------------------------------------------------------------
  // External clock input
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
    end else begin
      sck_s1_q <= ext_sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end

  // A level change counts only when the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sck_lvl_q <= 1'b0;
    else if (sck_s2_q == sck_s3_q) sck_lvl_q <= sck_s3_q;
  end

  assign ext_rise = (sck_s2_q == sck_s3_q) & sck_s3_q & ~sck_lvl_q;

  // ----------------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------------
  // Two half ticks make one cycle of the 16x clock; four make a sync bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_q <= 2'h0;
    else if (internal & tick_bus.half_tick) ph_q <= ph_q + 2'h1;
  end

  // Async: 16 x16 cycles of 2(N+1) ticks give the 32x factor
  assign x16_evt = internal ? (tick_bus.half_tick & ph_q[0])
                            : ext_rise;
  // Sync: 4 half periods of N+1 ticks give the 4x factor
  assign sync_evt = internal ? (tick_bus.half_tick
                               & (ph_q == `SBRG_SYNC_HALF_LAST))
                             : ext_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt16_q <= 4'h0;
    else if (mode == SBRG_SYNC) cnt16_q <= 4'h0;
    else if (x16_evt) cnt16_q <= cnt16_q + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_tick <= 1'b0;
      x16_tick <= 1'b0;
      sample_strobe <= 1'b0;
    end else if (mode == SBRG_ASYNC) begin
      bit_tick <= x16_evt & (cnt16_q == `SBRG_X16_LAST);
      x16_tick <= x16_evt;
      sample_strobe <= x16_evt & (cnt16_q == `SBRG_X16_SAMPLE);
    end else begin
      bit_tick <= sync_evt;
      x16_tick <= 1'b0;
      sample_strobe <= sync_evt;
    end
  end

  // ----------------------------------------------------------------------
  // Serial clock pin
  // ----------------------------------------------------------------------
  // Async drives a bit-rate clock only when asked; sync drives whenever the clock is internal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_out <= 1'b1;
      sck_oe <= 1'b0;
    end else begin
      sck_oe <= internal & ((mode == SBRG_SYNC)
                            | src_q[`SBRG_SRC_CLOCK_SOURCE_ENABLE_LO_BIT]);
      if (mode == SBRG_SYNC) sck_out <= ~ph_q[1];
      else sck_out <= ~cnt16_q[3];
    end
  end

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mp_format <= 1'b0;
      timer_clock_select <= 2'h0;
      i2c_control <= 4'h0;
      slave_input_switch <= 1'b0;
    end else begin
      // Format bit only counts with the enable set, and only in async
      mp_format <= stc_q[`SBRG_STC_MPE_BIT]
                 & mode_q[`SBRG_MODE_MP_BIT] & (mode == SBRG_ASYNC);
      timer_clock_select <= stc_q[1:0];
      i2c_control <= stc_q[7:4];
      slave_input_switch <= stc_q[`SBRG_STC_ACK_BIT];
    end
  end
endmodule

// file: test/sbrg_top_properties.sv
// Checker of the bit-rate generator top, bound to every instance of it.
// Assumes only the top ports; a shadow of written registers is kept here.
`timescale 1ns/100ps
`include "sbrg_regs.svh"
module sbrg_top_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sck_oe,
  input wire logic sck_out,
  input wire logic x16_tick,
  input wire logic bit_tick,
  input wire logic sample_strobe,
  input wire logic mp_format,
  input wire logic [1:0] timer_clock_select,
  input wire logic [3:0] i2c_control,
  input wire logic slave_input_switch
);
  // ---------------------------------------------------------------
  // Register shadow
  // ---------------------------------------------------------------
  logic [7:0] ctl_q;
  logic [7:0] mode_q;
  logic [1:0] src_q;
  logic wr_ok;
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_q <= 8'h00;
    else if (wr_ok && paddr == `SBRG_OFF_STC) ctl_q <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= 8'h00;
    else if (wr_ok && paddr == `SBRG_OFF_MODE) mode_q <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) src_q <= 2'h0;
    else if (wr_ok && paddr == `SBRG_OFF_SRC) src_q <= pwdata[1:0];
  end
  // x16 ticks since the last bit tick; cleared in sync mode, where the
  // design clears its own count too
  logic [3:0] x16_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) x16_n <= 4'h0;
    else if (mode_q[7]) x16_n <= 4'h0;
    else if (x16_tick) x16_n <= bit_tick ? 4'h0 : x16_n + 4'h1;
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && !pready; endsequence
  a_one_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("no answer after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_map: assert property (
    pready |-> pslverr == (paddr > `SBRG_OFF_STATUS
                           || paddr[1:0] != 2'h0))
    else $error("pslverr wrong for address");
  a_mp_off: assert property ((!ctl_q[2])[*3] |-> !mp_format)
    else $error("mp format while disabled");
  a_mp_on: assert property (
    (ctl_q[2] && mode_q[2] && !mode_q[7])[*3] |-> mp_format)
    else $error("mp format missing");
  a_ctl_route: assert property (ctl_q == $past(ctl_q, 2) |->
    {i2c_control, slave_input_switch, timer_clock_select} ==
    {ctl_q[7:3], ctl_q[1:0]})
    else $error("control bits not routed");
  a_sck_quiet: assert property (
    (!mode_q[7] && src_q == 2'h0)[*3] |-> !sck_oe)
    else $error("clock pin driven while unused");
  a_x16_sync: assert property ((mode_q[7])[*3] |-> !x16_tick)
    else $error("x16 tick in sync mode");
  a_sync_sample: assert property (
    (mode_q[7])[*3] |-> sample_strobe == bit_tick)
    else $error("sync sample not on bit tick");
  // Two async samples, so the pulse was launched in async mode as well
  sequence s_async; (!mode_q[7])[*2]; endsequence
  a_sample_mid: assert property (
    s_async ##0 sample_strobe |-> x16_tick && x16_n == 4'h7)
    else $error("sample strobe not on eighth x16 tick");
  a_bit_x16: assert property (
    s_async ##0 bit_tick |-> x16_tick && x16_n == 4'hf)
    else $error("bit tick not on sixteenth x16 tick");
  a_sck_bit: assert property (
    s_async ##0 bit_tick |-> !sck_out ##1 sck_out)
    else $error("serial clock not aligned to bit start");
endmodule
bind sbrg_top sbrg_top_properties chk (.pclk, .presetn, .paddr, .psel,
  .penable, .pwrite, .pwdata, .pstrb, .pready, .pslverr, .sck_oe, .sck_out,
  .x16_tick, .bit_tick, .sample_strobe, .mp_format, .timer_clock_select,
  .i2c_control, .slave_input_switch);

// file: test/sbrg_top_bench.sv
// Self-checking bench of the bit-rate generator top.
// Assumes a 10 MHz pclk; the external clock pin toggles only while
// ext_run is set, 4 cycles high and 4 low.
`timescale 1ns/100ps
module sbrg_top_bench;
  import sbrg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, ext_sck_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, i2c_control;
  logic pready, pslverr, sck_out, sck_oe, bit_tick, x16_tick;
  logic sample_strobe, mp_format, slave_input_switch;
  logic [1:0] timer_clock_select;
  logic ext_run;
  logic [32:0] rq[$];
  int pq[$];
  int failures, n_tests, cyc, per;
  sbrg_byte_t v;
  sbrg_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_sck_in(ext_sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .bit_tick(bit_tick), .x16_tick(x16_tick),
    .sample_strobe(sample_strobe), .mp_format(mp_format),
    .timer_clock_select(timer_clock_select), .i2c_control(i2c_control),
    .slave_input_switch(slave_input_switch));
  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // Watcher: read data and bit periods are matched to the oldest note
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      results();
    end
    if (psel && penable && pready && !pwrite) begin
      check({pslverr, prdata}, rq.pop_front());
    end
    if (bit_tick === 1'b1) begin
      if (pq.size() > 0) check(33'(per), 33'(pq.pop_front()));
      per <= 1;
    end else begin
      per <= per + 1;
    end
  end
  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  // External serial clock, well above the synchroniser's minimum width
  always @(posedge pclk) begin
    if (!ext_run) ext_sck_in <= 1'b0;
    else if (cyc[1:0] == 2'h3) ext_sck_in <= ~ext_sck_in;
  end
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, input logic [3:0] st,
                     input logic [32:0] exp);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pstrb <= st;
    pwdata <= {24'($urandom()), d};
    if (!wr) rq.push_back(exp);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bit period is measured on the third interval, after the old setting
  // and the prescaler phase have flushed out
  task automatic rate(input logic [7:0] m, input logic [7:0] n,
                      input logic [7:0] w, input int exp);
    apb(1'b1, 12'h000, m, 4'h1, '0);
    apb(1'b1, 12'h004, n, 4'h1, '0);
    apb(1'b1, 12'h00c, w, 4'h1, '0);
    repeat (2) @(posedge pclk iff bit_tick === 1'b1);
    @(posedge pclk);
    pq.push_back(exp);
    while (pq.size() > 0) @(posedge pclk);
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 0;
    ext_run = 0; presetn = 0; cyc = 0; per = 0;
    failures = 0; n_tests = 0;
    v = 8'($urandom(11));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h008, 8'h00, 4'h1, 33'h000000000);
    apb(1'b0, 12'h004, 8'h00, 4'h1, 33'h0000000ff);
    apb(1'b0, 12'h018, 8'h00, 4'h1, 33'h100000000);
    apb(1'b1, 12'h018, 8'h5a, 4'h1, '0);
    $display("reset values done");
    repeat (4) begin
      v = 8'($urandom());
      apb(1'b1, 12'h008, v, 4'h1, '0);
      apb(1'b0, 12'h008, 8'h00, 4'h1, {25'h0, v});
      repeat (2) @(posedge pclk);
      check({i2c_control, slave_input_switch, timer_clock_select},
            {v[7:3], v[1:0]});
    end
    apb(1'b1, 12'h008, ~v, 4'h0, '0);
    apb(1'b0, 12'h008, 8'h00, 4'h1, {25'h0, v});
    $display("control register done");
    apb(1'b1, 12'h000, 8'h04, 4'h1, '0);
    apb(1'b1, 12'h008, 8'h00, 4'h1, '0);
    repeat (3) @(posedge pclk);
    check(33'(mp_format), 33'h0);
    apb(1'b1, 12'h008, 8'h04, 4'h1, '0);
    repeat (3) @(posedge pclk);
    check(33'(mp_format), 33'h1);
    $display("multiprocessor enable done");
    rate(8'h00, 8'hff, 8'h00, 8192);
    rate(8'h00, 8'h03, 8'h00, 128);
    rate(8'h00, 8'h40, 8'h00, 2080);
    rate(8'h00, 8'h00, 8'h00, 32);
    rate(8'h01, 8'h00, 8'h00, 128);
    rate(8'h80, 8'h00, 8'h00, 4);
    check(33'(sck_oe), 33'h1);
    rate(8'h81, 8'h02, 8'h00, 48);
    rate(8'h81, 8'h02, 8'h08, 96);
    rate(8'h82, 8'h00, 8'h00, 64);
    rate(8'h82, 8'h00, 8'h08, 128);
    rate(8'h83, 8'h00, 8'h00, 256);
    rate(8'h83, 8'h00, 8'h08, 512);
    rate(8'h81, 8'h02, 8'h01, 96);
    rate(8'h80, 8'h02, 8'h01, 12);
    $display("bit rates done");
    apb(1'b1, 12'h010, 8'h02, 4'h1, '0);
    ext_run <= 1'b1;
    rate(8'h00, 8'h00, 8'h00, 128);
    rate(8'h80, 8'h00, 8'h00, 8);
    check(33'(sck_oe), 33'h0);
    ext_run <= 1'b0;
    apb(1'b1, 12'h010, 8'h01, 4'h1, '0);
    apb(1'b1, 12'h000, 8'h00, 4'h1, '0);
    repeat (3) @(posedge pclk);
    check(33'(sck_oe), 33'h1);
    $display("clock source done");
    results();
  end
endmodule
